// [port_irq_bank.sv]
// Purpose: one receive port's enable and sticky status registers
// Assumes: events are one-cycle pulses on clk
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/10ps
`default_nettype none
`include "rx_port_irq_consts.svh"

module port_irq_bank (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register access
  input wire logic wr_en_hi,
  input wire logic wr_en_lo,
  input wire rx_port_irq_pkg::reg_byte_t wdata,
  input wire logic clr_first,
  input wire logic clr_second,
  // events
  input wire logic enc_err,
  input wire logic seq_err,
  input wire logic crc_err,
  input wire logic line_length_change_flag,
  input wire logic line_count_change_flag,
  input wire logic buf_ovf,
  input wire logic parity_err,
  input wire logic port_valid_chg,
  input wire logic lock_chg,
  // state
  output rx_port_irq_pkg::reg_byte_t en_hi,
  output rx_port_irq_pkg::reg_byte_t en_lo,
  output rx_port_irq_pkg::reg_byte_t st_hi,
  output rx_port_irq_pkg::reg_byte_t st_lo,
  output logic irq
);
  import rx_port_irq_pkg::*;

  reg_byte_t en_hi_ff;
  reg_byte_t en_lo_ff;
  reg_byte_t st_hi_ff;
  reg_byte_t st_lo_ff;
  wire reg_byte_t set_hi = {5'b0_0000, enc_err, seq_err, crc_err};
  wire reg_byte_t set_lo = {1'b0, line_length_change_flag, line_count_change_flag, buf_ovf,
                            1'b0, parity_err, port_valid_chg, lock_chg};
  wire reg_byte_t clr_hi = {5'b0_0000, clr_second, clr_first, clr_first};
  wire reg_byte_t clr_lo = {1'b0, {3{clr_second}}, 1'b0, {3{clr_first}}};
  wire reg_byte_t nxt_st_hi = ((st_hi_ff & ~clr_hi) | set_hi) & `IRQ_HI_MASK;
  wire reg_byte_t nxt_st_lo = ((st_lo_ff & ~clr_lo) | set_lo) & `IRQ_LO_MASK;

  always_ff @(posedge clk) begin
    if (reset) begin
      en_hi_ff <= `IRQ_REG_RESET;
      en_lo_ff <= `IRQ_REG_RESET;
      st_hi_ff <= `IRQ_REG_RESET;
      st_lo_ff <= `IRQ_REG_RESET;
    end else begin
      if (wr_en_hi) en_hi_ff <= wdata & `IRQ_HI_MASK;
      if (wr_en_lo) en_lo_ff <= wdata & `IRQ_LO_MASK;
      st_hi_ff <= nxt_st_hi;
      st_lo_ff <= nxt_st_lo;
    end
  end

  assign en_hi = en_hi_ff;
  assign en_lo = en_lo_ff;
  assign st_hi = st_hi_ff;
  assign st_lo = st_lo_ff;
  assign irq = |(st_hi_ff & en_hi_ff) | |(st_lo_ff & en_lo_ff);
endmodule : port_irq_bank
`default_nettype wire

// [rx_port_error_interrupt_regs.sv]
// Purpose: banked per-port error interrupt enable and status registers
// Assumes: register port driven by the serial-control slave on clk
// Notes: read data one cycle after the read strobe
// Contract
// - port select register picks banked port copy
// - enable hi bit 2 raises encoding error
// - enable hi bit 1 raises sequence error
// - enable hi bit 0 raises CRC error
// - enable lo bit 6 raises line length change
// - enable lo bit 5 raises line count change
// - enable lo bit 4 raises buffer overflow
// - enable lo bit 2 raises parity error
// - enable lo bit 1 raises port valid change
// - enable lo bit 0 raises lock change
// - encoding status set; second status read clears
// - sequence status set; first status read clears
// - CRC status set; first status read clears
// - enable hi resets zero; reserved bits zero
// - line length status latched; second read clears
`timescale 1ns/10ps
`default_nettype none
`include "rx_port_irq_consts.svh"

module rx_port_error_interrupt_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire rx_port_irq_pkg::reg_byte_t reg_addr,
  input wire rx_port_irq_pkg::reg_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output rx_port_irq_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  // per-port events
  input wire rx_port_irq_pkg::port_vec_t enc_err,
  input wire rx_port_irq_pkg::port_vec_t seq_err,
  input wire rx_port_irq_pkg::port_vec_t crc_err,
  input wire rx_port_irq_pkg::port_vec_t line_length_change_flag,
  input wire rx_port_irq_pkg::port_vec_t line_count_change_flag,
  input wire rx_port_irq_pkg::port_vec_t buf_ovf,
  input wire rx_port_irq_pkg::port_vec_t parity_err,
  input wire rx_port_irq_pkg::port_vec_t port_valid_chg,
  input wire rx_port_irq_pkg::port_vec_t lock_chg,
  // interrupt requests
  output rx_port_irq_pkg::port_vec_t port_irq
);
  import rx_port_irq_pkg::*;

  port_idx_t sel_ff;
  reg_byte_t rd_data_ff;
  logic rd_valid_ff;
  reg_byte_t en_hi [`NUM_RX_PORTS];
  reg_byte_t en_lo [`NUM_RX_PORTS];
  reg_byte_t st_hi [`NUM_RX_PORTS];
  reg_byte_t st_lo [`NUM_RX_PORTS];

  wire logic hit_sel = reg_addr == `PORT_SEL_ADDR;
  wire logic hit_en_hi = reg_addr == `IRQ_EN_HI_ADDR;
  wire logic hit_en_lo = reg_addr == `IRQ_EN_LO_ADDR;
  wire logic hit_st_hi = reg_addr == `IRQ_ST_HI_ADDR;
  wire logic hit_st_lo = reg_addr == `IRQ_ST_LO_ADDR;
  wire logic hit_first = reg_addr == `RX_STS_FIRST_ADDR;
  wire logic hit_second = reg_addr == `RX_STS_SECOND_ADDR;

  // selected port's copies
  wire reg_byte_t sel_en_hi = en_hi[sel_ff];
  wire reg_byte_t sel_en_lo = en_lo[sel_ff];
  wire reg_byte_t sel_st_hi = st_hi[sel_ff];
  wire reg_byte_t sel_st_lo = st_lo[sel_ff];
  // port status views of the latched flags
  wire reg_byte_t sts_first = {3'b000, sel_st_hi[`BIT_CRC_ERR], sel_st_hi[`BIT_SEQ_ERR],
                               sel_st_lo[`BIT_PARITY], sel_st_lo[`BIT_PORT_VALID],
                               sel_st_lo[`BIT_LOCK]};
  wire reg_byte_t sts_second = {1'b0, sel_st_lo[`BIT_LINE_LEN], sel_st_lo[`BIT_LINE_CNT],
                                sel_st_lo[`BIT_BUF_OVF], 1'b0, sel_st_hi[`BIT_ENC_ERR],
                                2'b00};

  // unmapped addresses read zero
  wire reg_byte_t nxt_rd_data = hit_sel ? {6'b00_0000, sel_ff} :
                                hit_en_hi ? sel_en_hi :
                                hit_en_lo ? sel_en_lo :
                                hit_st_hi ? sel_st_hi :
                                hit_st_lo ? sel_st_lo :
                                hit_first ? sts_first :
                                hit_second ? sts_second : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_ff <= `PORT_SEL_RESET;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      if (reg_wr && hit_sel) sel_ff <= reg_wdata[1:0];
      rd_valid_ff <= reg_rd;
      if (reg_rd) rd_data_ff <= nxt_rd_data;
    end
  end

  assign reg_rdata = rd_data_ff;
  assign reg_rvalid = rd_valid_ff;

  genvar i;
  generate
    for (i = 0; i < `NUM_RX_PORTS; i++) begin : g_port
      wire logic mine = sel_ff == port_idx_t'(i);
      port_irq_bank u_bank (
        .clk(clk),
        .reset(reset),
        .wr_en_hi(reg_wr && hit_en_hi && mine),
        .wr_en_lo(reg_wr && hit_en_lo && mine),
        .wdata(reg_wdata),
        .clr_first(reg_rd && hit_first && mine),
        .clr_second(reg_rd && hit_second && mine),
        .enc_err(enc_err[i]),
        .seq_err(seq_err[i]),
        .crc_err(crc_err[i]),
        .line_length_change_flag(line_length_change_flag[i]),
        .line_count_change_flag(line_count_change_flag[i]),
        .buf_ovf(buf_ovf[i]),
        .parity_err(parity_err[i]),
        .port_valid_chg(port_valid_chg[i]),
        .lock_chg(lock_chg[i]),
        .en_hi(en_hi[i]),
        .en_lo(en_lo[i]),
        .st_hi(st_hi[i]),
        .st_lo(st_lo[i]),
        .irq(port_irq[i])
      );
    end
  endgenerate

  // checks on port 0, plus port select steering and readback
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic p0_sel = sel_ff == 2'h0;
  wire logic p0_wr_hi = reg_wr && hit_en_hi && p0_sel;
  wire logic p0_wr_lo = reg_wr && hit_en_lo && p0_sel;
  wire logic p0_rd_first = reg_rd && hit_first && p0_sel;
  wire logic p0_rd_second = reg_rd && hit_second && p0_sel;

  property p_sel_steers;
    reg_wr && hit_en_hi |=> en_hi[$past(sel_ff)] == ($past(reg_wdata) & 8'h07);
  endproperty
  a_sel_steers: assert property (p_sel_steers) else $error("port select misrouted write");

  property p_enc_irq;
    enc_err[0] && en_hi[0][2] && !p0_wr_hi |=> port_irq[0];
  endproperty
  a_enc_irq: assert property (p_enc_irq) else $error("encoding error did not interrupt");

  property p_seq_irq;
    seq_err[0] && en_hi[0][1] && !p0_wr_hi |=> port_irq[0];
  endproperty
  a_seq_irq: assert property (p_seq_irq) else $error("sequence error did not interrupt");

  property p_crc_set;
    crc_err[0] |=> st_hi[0][0] && (!en_hi[0][0] || port_irq[0]);
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc status not latched");

  property p_line_len;
    line_length_change_flag[0] && !p0_rd_second |=> st_lo[0][6] ##1 (st_lo[0][6] || $past(p0_rd_second));
  endproperty
  a_line_len: assert property (p_line_len) else $error("line length status lost");

  property p_lo_irq;
    (line_count_change_flag[0] && en_lo[0][5] || buf_ovf[0] && en_lo[0][4] ||
     parity_err[0] && en_lo[0][2] || port_valid_chg[0] && en_lo[0][1] ||
     lock_chg[0] && en_lo[0][0] || line_length_change_flag[0] && en_lo[0][6]) && !p0_wr_lo
    |=> port_irq[0];
  endproperty
  a_lo_irq: assert property (p_lo_irq) else $error("low event did not interrupt");

  property p_enc_clear;
    p0_rd_second && !enc_err[0] |=> !st_hi[0][2];
  endproperty
  a_enc_clear: assert property (p_enc_clear) else $error("encoding status not cleared");

  property p_seq_clear;
    p0_rd_first && !seq_err[0] ##0 st_hi[0][1] |=> !st_hi[0][1] && $past(reg_rd);
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequence status not cleared");

  property p_crc_clear;
    p0_rd_first && !crc_err[0] |=> !st_hi[0][0];
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc status not cleared");

  property p_len_clear;
    p0_rd_second && !line_length_change_flag[0] |=> !st_lo[0][6];
  endproperty
  a_len_clear: assert property (p_len_clear) else $error("line length not cleared");

  property p_en_lo;
    p0_wr_lo |=> en_lo[0] == ($past(reg_wdata) & 8'h77);
  endproperty
  a_en_lo: assert property (p_en_lo) else $error("enable lo lost");

  property p_sel_readback;
    reg_rd && hit_sel |=> reg_rvalid && reg_rdata == {6'b00_0000, $past(sel_ff)};
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("port select readback wrong");

  property p_reset_clear;
    $fell(reset) |-> en_hi[0] == 8'h00 && en_lo[0] == 8'h00 &&
                     port_irq == 4'h0 && sel_ff == 2'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

  property p_reserved_zero;
    reg_rd && hit_en_hi |=> reg_rvalid && reg_rdata[7:3] == 5'b0_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_irq_drop;
    $fell(port_irq[0]) |-> $past(reg_rd) || $past(reg_wr);
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq dropped without access");

  c_enc_irq: cover property (enc_err[0] && en_hi[0][2] ##1 port_irq[0]);
  c_clear_first: cover property (st_hi[0][0] && p0_rd_first ##1 !port_irq[0]);
  c_port_two: cover property (sel_ff == 2'h2 && reg_wr && hit_en_lo);
  c_len_clear: cover property (p0_rd_second && st_lo[0][6] ##1 !st_lo[0][6]);
endmodule : rx_port_error_interrupt_regs
`default_nettype wire

// [rx_port_error_interrupt_regs_tb.sv]
// Purpose: self-checking bench of the banked port error interrupt registers
// Assumes: host model drives the register port, bench drives events
// Notes: all sources exercised on ports 3 and 0
`timescale 1ns/10ps
`default_nettype none
`include "rx_port_irq_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module rx_port_error_interrupt_regs_tb;
  import rx_port_irq_pkg::*;
  logic clk;
  logic reset;
  reg_byte_t reg_addr;
  reg_byte_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  reg_byte_t reg_rdata;
  logic reg_rvalid;
  port_vec_t ev [9];
  port_vec_t port_irq;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int bitpos [9] = '{2, 1, 0, 6, 5, 4, 2, 1, 0};
  // bit of each source in the port status view that clears it
  int stspos [9] = '{2, 3, 4, 6, 5, 4, 2, 1, 0};

  rx_port_error_interrupt_regs u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .enc_err(ev[0]), .seq_err(ev[1]), .crc_err(ev[2]),
    .line_length_change_flag(ev[3]), .line_count_change_flag(ev[4]), .buf_ovf(ev[5]), .parity_err(ev[6]),
    .port_valid_chg(ev[7]), .lock_chg(ev[8]), .port_irq(port_irq));
  rx_port_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic rchk(input string n, input reg_byte_t a, input reg_byte_t e);
    reg_byte_t d;
    logic v;
    u_host.rd(a, d, v);
    `CHK(n, 1'b1, v)
    `CHK(n, e, d)
  endtask : rchk

  // one-cycle event, then one edge so the latched status is visible
  task automatic pulse(input int k, input int p);
    @(posedge clk);
    ev[k][p] <= 1'b1;
    @(posedge clk);
    ev[k][p] <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic t_reset();
    rchk("en_hi", `IRQ_EN_HI_ADDR, 8'h00);
    rchk("en_lo", `IRQ_EN_LO_ADDR, 8'h00);
    rchk("st_hi", `IRQ_ST_HI_ADDR, 8'h00);
    rchk("st_lo", `IRQ_ST_LO_ADDR, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    `CHK("irq", 4'h0, port_irq)
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable_bank();
    u_host.wr(`PORT_SEL_ADDR, 8'h03);
    u_host.wr(`IRQ_EN_HI_ADDR, 8'hFF);
    rchk("sel_rb", `PORT_SEL_ADDR, 8'h03);
    rchk("en_hi_wr", `IRQ_EN_HI_ADDR, 8'h07);
    u_host.wr(`IRQ_EN_LO_ADDR, 8'hFF);
    rchk("en_lo_wr", `IRQ_EN_LO_ADDR, 8'h77);
    u_host.wr(`PORT_SEL_ADDR, 8'h00);
    rchk("en_hi_p0", `IRQ_EN_HI_ADDR, 8'h00);
    u_host.wr(`PORT_SEL_ADDR, 8'h03);
    $display("test enable and banking done");
  endtask : t_enable_bank

  task automatic t_sources(input int p);
    reg_byte_t sa;
    reg_byte_t ca;
    port_vec_t pi;
    pi = port_vec_t'(1 << p);
    u_host.wr(`PORT_SEL_ADDR, reg_byte_t'(p));
    u_host.wr(`IRQ_EN_HI_ADDR, 8'hFF);
    u_host.wr(`IRQ_EN_LO_ADDR, 8'hFF);
    for (int k = 0; k < 9; k++) begin
      sa = (k < 3) ? `IRQ_ST_HI_ADDR : `IRQ_ST_LO_ADDR;
      ca = (k == 0 || (k >= 3 && k <= 5)) ? `RX_STS_SECOND_ADDR : `RX_STS_FIRST_ADDR;
      pulse(k, p);
      `CHK("irq_set", pi, port_irq)
      rchk("st_set", sa, 8'h01 << bitpos[k]);
      `CHK("irq_held", pi, port_irq)
      rchk("sts_view", ca, 8'h01 << stspos[k]);
      rchk("st_clr", sa, 8'h00);
      `CHK("irq_clr", 4'h0, port_irq)
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_mask();
    reg_byte_t d;
    logic v;
    u_host.wr(`IRQ_EN_HI_ADDR, 8'h03);
    pulse(0, 3);
    pulse(1, 0);
    `CHK("irq_masked", 4'h0, port_irq)
    rchk("st_masked", `IRQ_ST_HI_ADDR, 8'h04);
    u_host.rd(`RX_STS_FIRST_ADDR, d, v);
    rchk("st_wrong_clr", `IRQ_ST_HI_ADDR, 8'h04);
    u_host.wr(`PORT_SEL_ADDR, 8'h00);
    rchk("st_p0", `IRQ_ST_HI_ADDR, 8'h02);
    rchk("sts_p0", `RX_STS_FIRST_ADDR, 8'h08);
    rchk("st_p0_clr", `IRQ_ST_HI_ADDR, 8'h00);
    $display("test mask done");
  endtask : t_mask

  task automatic t_midreset();
    u_host.wr(`PORT_SEL_ADDR, 8'h02);
    u_host.wr(`IRQ_EN_HI_ADDR, 8'h07);
    u_host.wr(`IRQ_EN_LO_ADDR, 8'h01);
    pulse(0, 2);
    `CHK("irq_pre", 4'h4, port_irq)
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rchk("sel_rst", `PORT_SEL_ADDR, 8'h00);
    rchk("en_hi_rst", `IRQ_EN_HI_ADDR, 8'h00);
    `CHK("irq_rst", 4'h0, port_irq)
    $display("test mid-run reset done");
  endtask : t_midreset

  initial begin
    reset = 1'b1;
    foreach (ev[i]) ev[i] = 4'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_enable_bank();
    t_sources(3);
    t_mask();
    t_sources(0);
    t_midreset();
    end_sim();
  end
endmodule : rx_port_error_interrupt_regs_tb

`undef CHK
`default_nettype wire

// [rx_port_host_model.sv]
// Purpose: host side of the register port, issuing single reads and writes
// Assumes: requests launched just after rising edges of clk
// Notes: write data idles inverted after release
`timescale 1ns/10ps
`default_nettype none

module rx_port_host_model (
  // clock
  input wire logic clk,
  // register port
  output rx_port_irq_pkg::reg_byte_t reg_addr,
  output rx_port_irq_pkg::reg_byte_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire rx_port_irq_pkg::reg_byte_t reg_rdata,
  input wire logic reg_rvalid
);
  import rx_port_irq_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // answer sampled exactly one cycle after the strobe is taken
  task automatic rd(input reg_byte_t a, output reg_byte_t d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : rx_port_host_model

`default_nettype wire

// [rx_port_irq_consts.svh]
// Purpose: offsets, field masks and reset values of the per-port interrupt registers
// Assumes: 8-bit register addresses and data
// Notes: definitions only
`ifndef RX_PORT_IRQ_CONSTS_SVH
`define RX_PORT_IRQ_CONSTS_SVH

`define NUM_RX_PORTS 4
`define PORT_SEL_ADDR 8'h4C
`define IRQ_EN_HI_ADDR 8'hD8
`define IRQ_EN_LO_ADDR 8'hD9
`define IRQ_ST_HI_ADDR 8'hDA
`define IRQ_ST_LO_ADDR 8'hDB
`define RX_STS_FIRST_ADDR 8'hF0
`define RX_STS_SECOND_ADDR 8'hF1

`define IRQ_HI_MASK 8'h07
`define IRQ_LO_MASK 8'h77
`define IRQ_REG_RESET 8'h00
`define PORT_SEL_RESET 2'h0

`define BIT_ENC_ERR 2
`define BIT_SEQ_ERR 1
`define BIT_CRC_ERR 0
`define BIT_LINE_LEN 6
`define BIT_LINE_CNT 5
`define BIT_BUF_OVF 4
`define BIT_PARITY 2
`define BIT_PORT_VALID 1
`define BIT_LOCK 0

`endif

// [rx_port_irq_pkg.sv]
// Purpose: shared types of the per-port interrupt registers
// Assumes: four receive ports
// Notes: constants live in rx_port_irq_consts.svh
`default_nettype none
package rx_port_irq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] port_idx_t;
  typedef logic [3:0] port_vec_t;
endpackage : rx_port_irq_pkg
`default_nettype wire
